// >>> logic/sdp_regs.sv
/*
  write-only register bank behind a three-wire serial port: loop power,
  feedback and reference divider values, gain codes and auto override.
  assumes serial pins sampled on clk_in; frame is 22 bits MSB first
  (data 17..0 then address 3..0) shifted on sclk rising edges while sen_n
  is low, committed when sen_n rises.
*/
`timescale 1ns/1ps
module sdp_regs
(
  input  wire logic                                 clk_in,
  input  wire logic                                 resetn_in,
  input  wire logic                                 ce_in,
  input  wire sdp_pkg::sdp_serial_t                 serial_in,
  output            sdp_pkg::sdp_loop_t             loop_out,
  output logic                                      auto_power_override_out,
  output logic      [sdp_pkg::RF1_FB_W-1:0]         rf1_feedback_count_out,
  output logic      [sdp_pkg::RF2_FB_W-1:0]         rf2_feedback_count_out,
  output logic      [sdp_pkg::IF_FB_W-1:0]          if_feedback_count_out,
  output logic      [sdp_pkg::REF_W-1:0]            rf1_reference_count_out,
  output logic      [sdp_pkg::REF_W-1:0]            rf2_reference_count_out,
  output logic      [sdp_pkg::REF_W-1:0]            if_reference_count_out,
  output logic      [sdp_pkg::GAIN_W-1:0]           rf1_gain_code_out,
  output logic      [sdp_pkg::GAIN_W-1:0]           rf2_gain_code_out,
  output logic      [sdp_pkg::GAIN_W-1:0]           if_gain_code_out
);
  import sdp_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] k);
    hit = (a == k);
  endfunction : hit

  // =====================================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // =====================================================================
  // serial frame capture
  sdp_state_t              state_q;
  sdp_state_t              state_d;
  logic                    sclk_prev_q;
  logic [FRAME_BITS-1:0]   shift_q;
  logic [CNT_W-1:0]        cnt_q;
  logic                    sclk_rise;
  logic                    commit;
  logic [DATA_W-1:0]       wdata;
  logic [ADDR_W-1:0]       waddr;

  assign sclk_rise = serial_in.sclk & ~sclk_prev_q;
  assign commit    = (state_q == ST_SHIFT) && serial_in.sen_n && (cnt_q == FRAME_COUNT); // R1
  assign wdata     = shift_q[FRAME_BITS-1:ADDR_W];  // R1
  assign waddr     = shift_q[ADDR_W-1:0];           // R1

  always_comb
  begin
    case (state_q)
      ST_IDLE:  state_d = serial_in.sen_n ? ST_IDLE : ST_SHIFT;
      ST_SHIFT: state_d = serial_in.sen_n ? ST_IDLE : ST_SHIFT;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q     <= ST_IDLE;
      sclk_prev_q <= 1'b0;
      shift_q     <= '0;
      cnt_q       <= '0;
    end
    else if (ce_in)
    begin
      state_q     <= state_d;
      sclk_prev_q <= serial_in.sclk;
      if (serial_in.sen_n)
        cnt_q <= '0;
      else if (sclk_rise)
      begin
        shift_q <= {shift_q[FRAME_BITS-2:0], serial_in.sdata};
        // saturate so an overlong frame is never taken
        cnt_q   <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
      end
    end
  end

  // =====================================================================
  // register writes; reserved bits are dropped
  logic                 wr_cfg;
  logic                 wr_gain;
  logic                 wr_pwr;
  logic                 wr_rf1_fb;
  logic                 wr_rf2_fb;
  logic                 wr_if_fb;
  logic                 wr_rf1_ref;
  logic                 wr_rf2_ref;
  logic                 wr_if_ref;
  logic                 ovr_q;
  logic                 ovr_d;
  logic [1:0]           pwr_q;
  logic [1:0]           pwr_d;
  logic                 if_on_d;
  logic                 rf_on_d;
  logic [3*GAIN_W-1:0]  gain_q;
  logic [RF1_FB_W-1:0]  rf1_fb_q;
  logic [RF2_FB_W-1:0]  rf2_fb_q;
  logic [IF_FB_W-1:0]   if_fb_q;
  logic [REF_W-1:0]     rf1_ref_q;
  logic [REF_W-1:0]     rf2_ref_q;
  logic [REF_W-1:0]     if_ref_q;
  sdp_loop_t            loop_q;
  sdp_loop_t            loop_d;

  assign wr_cfg     = commit && hit(waddr, ADDR_MAIN_CONFIG);
  assign wr_gain    = commit && hit(waddr, ADDR_GAIN);
  assign wr_pwr     = commit && hit(waddr, ADDR_LOOP_POWER);    // R2
  assign wr_rf1_fb  = commit && hit(waddr, ADDR_RF1_FEEDBACK);
  assign wr_rf2_fb  = commit && hit(waddr, ADDR_RF2_FEEDBACK);
  assign wr_if_fb   = commit && hit(waddr, ADDR_IF_FEEDBACK);
  assign wr_rf1_ref = commit && hit(waddr, ADDR_RF1_REFERENCE);
  assign wr_rf2_ref = commit && hit(waddr, ADDR_RF2_REFERENCE);
  assign wr_if_ref  = commit && hit(waddr, ADDR_IF_REFERENCE);

  assign ovr_d = wr_cfg ? wdata[AUTO_OVERRIDE_BIT] : ovr_q;
  assign pwr_d = wr_pwr ? {wdata[IF_LOOP_ON_BIT], wdata[RF_LOOP_ON_BIT]} : pwr_q; // R2

  assign if_on_d = ovr_d | pwr_d[1];                                           // R3 R16
  assign rf_on_d = ovr_d | pwr_d[0];                                           // R4 R16
  assign loop_d  = '{if_loop_on: if_on_d, rf_loop_on: rf_on_d, ref_amp_on: if_on_d | rf_on_d}; // R5

  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ovr_q     <= RESET_WORD[0];
      pwr_q     <= RESET_WORD[1:0];
      gain_q    <= RESET_WORD[3*GAIN_W-1:0];
      rf1_fb_q  <= RESET_WORD[RF1_FB_W-1:0];
      rf2_fb_q  <= RESET_WORD[RF2_FB_W-1:0];
      if_fb_q   <= RESET_WORD[IF_FB_W-1:0];
      rf1_ref_q <= RESET_WORD[REF_W-1:0];
      rf2_ref_q <= RESET_WORD[REF_W-1:0];
      if_ref_q  <= RESET_WORD[REF_W-1:0];
      loop_q    <= '0;
    end
    else if (ce_in)
    begin
      ovr_q  <= ovr_d;
      pwr_q  <= pwr_d;
      loop_q <= loop_d;
      if (wr_gain)    gain_q    <= wdata[3*GAIN_W-1:0];   // R15
      if (wr_rf1_fb)  rf1_fb_q  <= wdata[RF1_FB_W-1:0];   // R6
      if (wr_rf2_fb)  rf2_fb_q  <= wdata[RF2_FB_W-1:0];   // R7
      if (wr_if_fb)   if_fb_q   <= wdata[IF_FB_W-1:0];    // R8
      if (wr_rf1_ref) rf1_ref_q <= wdata[REF_W-1:0];      // R9
      if (wr_rf2_ref) rf2_ref_q <= wdata[REF_W-1:0];      // R11
      if (wr_if_ref)  if_ref_q  <= wdata[REF_W-1:0];      // R13
    end
  end

  // range limits on the reference counts are the host's to keep; the values pass through as written
  assign loop_out                = loop_q;
  assign auto_power_override_out = ovr_q;
  assign rf1_feedback_count_out  = rf1_fb_q;
  assign rf2_feedback_count_out  = rf2_fb_q;
  assign if_feedback_count_out   = if_fb_q;
  assign rf1_reference_count_out = rf1_ref_q;  // R10
  assign rf2_reference_count_out = rf2_ref_q;  // R12
  assign if_reference_count_out  = if_ref_q;   // R14
  assign rf1_gain_code_out       = gain_q[RF1_GAIN_LSB +: GAIN_W];
  assign rf2_gain_code_out       = gain_q[RF2_GAIN_LSB +: GAIN_W];
  assign if_gain_code_out        = gain_q[IF_GAIN_LSB +: GAIN_W];

  // =====================================================================
  // assertions
  property p_short_frame;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && state_q == ST_SHIFT && serial_in.sen_n && cnt_q != FRAME_COUNT) |=> $stable(rf1_fb_q) && $stable(pwr_q);
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("frame of wrong length was committed"); // R1

  property p_if_on;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_pwr && !ovr_q && !wr_cfg) |=> loop_out.if_loop_on == $past(wdata[1]);
  endproperty
  a_if_on: assert property (p_if_on) else $error("if loop enable does not follow write"); // R3

  property p_rf_on;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_pwr && !ovr_q && !wr_cfg) |=> loop_out.rf_loop_on == $past(wdata[0]);
  endproperty
  a_rf_on: assert property (p_rf_on) else $error("rf loop enable does not follow write"); // R4

  property p_ref_amp;
    @(posedge clk_in) disable iff (!rst_n_q)
    loop_out.ref_amp_on == (loop_out.if_loop_on || loop_out.rf_loop_on);
  endproperty
  a_ref_amp: assert property (p_ref_amp) else $error("reference amplifier state wrong"); // R5

  property p_rf1_fb;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_rf1_fb) |=> rf1_feedback_count_out == $past(wdata);
  endproperty
  a_rf1_fb: assert property (p_rf1_fb) else $error("rf1 feedback count not stored"); // R6

  property p_rf2_fb;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_rf2_fb) |=> rf2_feedback_count_out == $past(wdata[16:0]);
  endproperty
  a_rf2_fb: assert property (p_rf2_fb) else $error("rf2 feedback count not stored"); // R7

  property p_if_fb;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_if_fb) |=> if_feedback_count_out == $past(wdata[15:0]);
  endproperty
  a_if_fb: assert property (p_if_fb) else $error("if feedback count not stored"); // R8

  property p_rf1_ref;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_rf1_ref) |=> rf1_reference_count_out == $past(wdata[12:0]);
  endproperty
  a_rf1_ref: assert property (p_rf1_ref) else $error("rf1 reference count not stored"); // R9

  property p_rf2_ref;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_rf2_ref) |=> rf2_reference_count_out == $past(wdata[12:0]);
  endproperty
  a_rf2_ref: assert property (p_rf2_ref) else $error("rf2 reference count not stored"); // R11

  property p_if_ref;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_if_ref) |=> if_reference_count_out == $past(wdata[12:0]);
  endproperty
  a_if_ref: assert property (p_if_ref) else $error("if reference count not stored"); // R13

  property p_gain;
    @(posedge clk_in) disable iff (!rst_n_q)
    (ce_in && wr_gain) |=> if_gain_code_out == $past(wdata[5:4]) && rf2_gain_code_out == $past(wdata[3:2])
                           && rf1_gain_code_out == $past(wdata[1:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain codes not stored"); // R15

  property p_override;
    @(posedge clk_in) disable iff (!rst_n_q)
    auto_power_override_out |-> loop_out.if_loop_on && loop_out.rf_loop_on;
  endproperty
  a_override: assert property (p_override) else $error("override did not force loops on"); // R16

  property p_hold;
    @(posedge clk_in) disable iff (!rst_n_q)
    !(ce_in && wr_rf2_ref) |=> $stable(rf2_reference_count_out);
  endproperty
  a_hold: assert property (p_hold) else $error("rf2 reference changed without write"); // R17

  c_pwr_write: cover property (@(posedge clk_in) disable iff (!rst_n_q) ce_in && wr_pwr);
  c_override:  cover property (@(posedge clk_in) disable iff (!rst_n_q) ce_in && wr_cfg && wdata[AUTO_OVERRIDE_BIT]);
  c_rf1_write: cover property (@(posedge clk_in) disable iff (!rst_n_q) ce_in && wr_rf1_fb);

endmodule : sdp_regs

// >>> logic/sdp_pkg.sv
/*
  constants, field layouts and carrier types of the synthesizer divider and
  powerdown register bank.
  assumes a single 40 MHz clock; serial pins are synchronous to that clock.
*/
// Summary of operation
// [R1] frames carry 18 data bits, 4-bit address
// [R2] powerdown at address 2, upper bits ignored
// [R3] bit 1 turns the IF loop on
// [R4] bit 0 turns the RF loop on
// [R5] reference amplifier on when any loop on
// [R6] address 3 holds full 18-bit RF1 feedback
// [R7] address 4 holds 17-bit RF2 feedback
// [R8] address 5 holds 16-bit IF feedback
// [R9] address 6 holds 13-bit RF1 reference
// [R10] host keeps RF1 reference in gain range
// [R11] address 7 holds 13-bit RF2 reference
// [R12] host keeps RF2 reference in gain range
// [R13] address 8 holds 13-bit IF reference
// [R14] host keeps IF reference in gain range
// [R15] gain register holds three two-bit gain codes
// [R16] auto override forces both loops on
// [R17] registers hold until rewritten
package sdp_pkg;

  // =====================================================================
  // frame layout
  localparam int unsigned DATA_W     = 18;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned FRAME_BITS = DATA_W + ADDR_W;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] FRAME_COUNT = 5'h16;

  // =====================================================================
  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_MAIN_CONFIG    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_GAIN           = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_LOOP_POWER     = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_RF1_FEEDBACK   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_RF2_FEEDBACK   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IF_FEEDBACK    = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_RF1_REFERENCE  = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_RF2_REFERENCE  = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_IF_REFERENCE   = 4'h8;

  // =====================================================================
  // field positions and widths
  localparam int unsigned IF_LOOP_ON_BIT    = 1;
  localparam int unsigned RF_LOOP_ON_BIT    = 0;
  localparam int unsigned AUTO_OVERRIDE_BIT = 3;
  localparam int unsigned RF1_GAIN_LSB      = 0;
  localparam int unsigned RF2_GAIN_LSB      = 2;
  localparam int unsigned IF_GAIN_LSB       = 4;
  localparam int unsigned GAIN_W            = 2;
  localparam int unsigned RF1_FB_W          = 18;
  localparam int unsigned RF2_FB_W          = 17;
  localparam int unsigned IF_FB_W           = 16;
  localparam int unsigned REF_W             = 13;

  // =====================================================================
  // values after reset: everything off and cleared
  localparam logic [DATA_W-1:0] RESET_WORD = 18'h0_0000;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic sen_n;
    logic sclk;
    logic sdata;
  } sdp_serial_t;

  typedef struct packed {
    logic if_loop_on;
    logic rf_loop_on;
    logic ref_amp_on;
  } sdp_loop_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} sdp_state_t;

endpackage : sdp_pkg

// >>> bench/sdp_host_model.sv
/*
  host controller model: writes frames over the three-wire serial port.
  assumes the bank samples the pins on clk_in; pins change on falling edges.
*/
`timescale 1ns/1ps
module sdp_host_model
(
  input  wire logic           clk_in,
  output var  sdp_pkg::sdp_serial_t serial_out
);
  import sdp_pkg::*;

  initial serial_out = '{sen_n: 1'b1, sclk: 1'b0, sdata: 1'b0};

  // =====================================================================
  // frame writer: msb first, data then address, clock idles low
  task automatic send(input logic [FRAME_BITS-1:0] frame, input int nbits);
    @(negedge clk_in);
    serial_out.sen_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      @(negedge clk_in);
      serial_out.sclk  = 1'b0;
      serial_out.sdata = frame[i];
      @(negedge clk_in);
      serial_out.sclk = 1'b1;
    end
    @(negedge clk_in);
    serial_out.sclk  = 1'b0;
    serial_out.sdata = ~serial_out.sdata;
    @(negedge clk_in);
    serial_out.sen_n = 1'b1;
    @(negedge clk_in);
  endtask : send
endmodule : sdp_host_model

// >>> bench/tb_synth_divider_powerdown_regs.sv
/*
  self-checking bench of the divider and powerdown register bank.
  assumes the host model drives the serial pins and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb_synth_divider_powerdown_regs;
  import sdp_pkg::*;

  logic                  clk_in    = 1'b0;
  logic                  resetn_in = 1'b0;
  logic                  ce_in     = 1'b1;
  sdp_serial_t           serial;
  sdp_loop_t             loop;
  logic                  auto_ov;
  logic [RF1_FB_W-1:0]   rf1_fb;
  logic [RF2_FB_W-1:0]   rf2_fb;
  logic [IF_FB_W-1:0]    if_fb;
  logic [REF_W-1:0]      rf1_ref;
  logic [REF_W-1:0]      rf2_ref;
  logic [REF_W-1:0]      if_ref;
  logic [GAIN_W-1:0]     rf1_gain;
  logic [GAIN_W-1:0]     rf2_gain;
  logic [GAIN_W-1:0]     if_gain;
  logic [DATA_W-1:0]     exp_q [0:15];
  int                    fail_count = 0;
  int                    n_tests    = 0;

  always #12.5 clk_in = ~clk_in;

  sdp_host_model host (.clk_in(clk_in), .serial_out(serial));

  sdp_regs dut
  (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .serial_in(serial), .loop_out(loop),
    .auto_power_override_out(auto_ov), .rf1_feedback_count_out(rf1_fb), .rf2_feedback_count_out(rf2_fb),
    .if_feedback_count_out(if_fb), .rf1_reference_count_out(rf1_ref), .rf2_reference_count_out(rf2_ref),
    .if_reference_count_out(if_ref), .rf1_gain_code_out(rf1_gain), .rf2_gain_code_out(rf2_gain),
    .if_gain_code_out(if_gain)
  );

  // =====================================================================
  // helpers
  task automatic check(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic check_all();
    logic ov;
    ov = exp_q[0][AUTO_OVERRIDE_BIT];
    check("auto_override", DATA_W'(ov), DATA_W'(auto_ov));
    check("if_loop_on", DATA_W'(exp_q[2][1] | ov), DATA_W'(loop.if_loop_on));
    check("rf_loop_on", DATA_W'(exp_q[2][0] | ov), DATA_W'(loop.rf_loop_on));
    check("ref_amp_on", DATA_W'(exp_q[2][1] | exp_q[2][0] | ov), DATA_W'(loop.ref_amp_on));
    check("rf1_feedback", exp_q[3], DATA_W'(rf1_fb));
    check("rf2_feedback", DATA_W'(exp_q[4][16:0]), DATA_W'(rf2_fb));
    check("if_feedback", DATA_W'(exp_q[5][15:0]), DATA_W'(if_fb));
    check("rf1_reference", DATA_W'(exp_q[6][12:0]), DATA_W'(rf1_ref));
    check("rf2_reference", DATA_W'(exp_q[7][12:0]), DATA_W'(rf2_ref));
    check("if_reference", DATA_W'(exp_q[8][12:0]), DATA_W'(if_ref));
    check("gain_codes", DATA_W'(exp_q[1][5:0]), DATA_W'({if_gain, rf2_gain, rf1_gain}));
  endtask : check_all

  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    host.send({data, addr}, FRAME_BITS);
    exp_q[addr] = data;
    repeat (2) @(negedge clk_in);
  endtask : wr

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // =====================================================================
  // sequence
  initial
  begin
    foreach (exp_q[i]) exp_q[i] = RESET_WORD;
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check_all();
    $display("test reset done");
    for (int v = 0; v < 4; v++)
    begin
      wr(ADDR_LOOP_POWER, DATA_W'(v));
      check_all();
    end
    $display("test loop power done");
    wr(ADDR_GAIN, 18'h0_0039);
    wr(ADDR_RF1_FEEDBACK, 18'h2_A5C3);
    wr(ADDR_RF2_FEEDBACK, 18'h1_5A3C);
    wr(ADDR_IF_FEEDBACK, 18'h0_C3A5);
    wr(ADDR_RF1_REFERENCE, 18'h0_1FFD);
    wr(ADDR_RF2_REFERENCE, 18'h0_000A);
    wr(ADDR_IF_REFERENCE, 18'h0_000E);
    check_all();
    $display("test dividers done");
    host.send({18'h0_1555, ADDR_RF1_FEEDBACK}, FRAME_BITS - 1);
    host.send({18'h0_1555, 4'h9}, FRAME_BITS);
    ce_in = 1'b0;
    host.send({18'h0_0000, ADDR_LOOP_POWER}, FRAME_BITS);
    ce_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check_all();
    $display("test refused frames done");
    wr(ADDR_LOOP_POWER, 18'h0_0001);
    wr(ADDR_MAIN_CONFIG, 18'h0_0008);
    check_all();
    wr(ADDR_MAIN_CONFIG, 18'h0_0000);
    wr(ADDR_RF1_FEEDBACK, 18'h1_0001);
    check_all();
    $display("test override done");
    tally_and_finish();
  end
endmodule : tb_synth_divider_powerdown_regs
